// [hw/scr_clk_gen.sv]
// module: base pulses and card clock with duty-safe stop
`timescale 1ns/1ps
`default_nettype none
module scr_clk_gen (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // control
  input wire logic enable_in,
  input wire logic [7:0] half_div_in,
  input wire logic clk_out_on_in,
  input wire logic fix_level_in,
  // results
  output logic base_tick_out,
  output logic sck_level_out,
  output logic running_out
);

  logic [7:0] half_cnt_reg;
  logic phase_reg;
  logic boundary;
  logic phase_next;
  logic run_next;

  assign boundary = enable_in && (half_cnt_reg == half_div_in);
  assign phase_next = ~phase_reg;

  // stop and start only at the fixed level
  assign run_next = clk_out_on_in ? running_out | (phase_reg == fix_level_in) :
                    running_out & (phase_next != fix_level_in);

  // ==========================================================
  // half-period divider
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      half_cnt_reg <= 8'h00;
      phase_reg <= 1'b0;
    end else if (!enable_in) begin
      half_cnt_reg <= 8'h00;
      phase_reg <= 1'b0;
    end else if (boundary) begin
      half_cnt_reg <= 8'h00;
      phase_reg <= phase_next;
    end else begin
      half_cnt_reg <= half_cnt_reg + 8'h01;
    end
  end

  // ==========================================================
  // base pulse on each rising phase
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      base_tick_out <= 1'b0;
      running_out <= 1'b0;
      sck_level_out <= 1'b0;
    end else begin
      base_tick_out <= boundary && !phase_reg;
      if (!enable_in) begin
        running_out <= 1'b0;
        sck_level_out <= fix_level_in;
      end else if (boundary) begin
        running_out <= run_next;
        sck_level_out <= run_next ? phase_next : fix_level_in;
      end else if (!running_out) begin
        sck_level_out <= fix_level_in;
      end
    end
  end

endmodule // scr_clk_gen
`default_nettype wire

// [hw/scr_pkg.sv]
// package: register map, timing and types of the card serial block
package scr_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [4:0] OFS_SERIAL_MODE = 5'h00;
  localparam logic [4:0] OFS_CARD_MODE = 5'h04;
  localparam logic [4:0] OFS_SERIAL_CONTROL = 5'h08;
  localparam logic [4:0] OFS_SERIAL_FLAGS = 5'h0C;
  localparam logic [4:0] OFS_TX_DATA = 5'h10;
  localparam logic [4:0] OFS_RX_DATA = 5'h14;
  localparam logic [4:0] OFS_BIT_RATE = 5'h18;
  localparam logic [4:0] OFS_PORT = 5'h1C;

  // ==========================================================
  // field positions
  localparam int MODE_PARITY_ODD = 0;
  localparam int CARD_MODE_SELECT = 0;
  localparam int CTRL_TX_ON = 0;
  localparam int CTRL_RX_ON = 1;
  localparam int CTRL_CLK_OUT_ON = 2;
  localparam int CTRL_CLK_FIXED_LEVEL = 3;
  localparam int CTRL_TX_IRQ_MASK = 4;
  localparam int CTRL_RX_IRQ_MASK = 5;
  localparam int FLAG_TX_DONE = 0;
  localparam int FLAG_RX_FULL = 1;
  localparam int FLAG_PARITY_FAULT = 2;
  localparam int FLAG_ERROR_SIGNAL = 3;
  localparam int FLAG_BUSY = 4;
  localparam int PORT_CLK_DIR = 0;
  localparam int PORT_CLK_VALUE = 1;
  localparam int PORT_CLK_PIN = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] BIT_RATE_RESET = 8'h03;
  localparam logic TX_DONE_RESET = 1'b1;

  // ==========================================================
  // frame timing
  localparam logic [8:0] BASE_PER_BIT = 9'h174;
  localparam logic [8:0] SAMPLE_PULSE = 9'h0BA;
  localparam logic [8:0] ERR_PROBE_PULSE = 9'h001;
  localparam logic [3:0] BIT_START = 4'h0;
  localparam logic [3:0] BIT_PARITY = 4'h9;
  localparam logic [3:0] BIT_ERR_OPEN = 4'hA;
  localparam logic [3:0] BIT_ERR_CLOSE = 4'hB;
  localparam logic [3:0] BIT_LAST = 4'hB;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FRAME = 2'b01
  } scr_state_t;

  typedef struct packed {
    logic rx_irq_mask;
    logic tx_irq_mask;
    logic clk_fixed_level;
    logic clk_out_on;
    logic rx_on;
    logic tx_on;
  } scr_ctrl_t;

  typedef struct packed {
    logic error_signal_flag;
    logic parity_fault_flag;
    logic receive_full_flag;
    logic tx_done_flag;
  } scr_flags_t;

endpackage

// [hw/scr_top.sv]
// module: smart-card serial interface with error signalling and retransfer
//
// Behaviour
// - 372 base pulses per bit
// - start fall aligns bit timing
// - bit latched at pulse 186
// - bad parity sets fault, fault irq
// - bad parity never sets receive full
// - good parity sets full, receive irq
// - good frame releases error slot
// - error signal sets flag, fault irq
// - errored frame never sets done
// - no error signal, flag unchanged
// - no error signal: done, transmit irq
// - errored frame repeats, done stays clear
// - stop finishes period, holds fixed level; pin driven only when that level is high
// - restart from fixed level, full duty
// - clock pin undriven after reset
// - leaving card mode releases data pins
// - clock output on drives clock pin
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module scr_top (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // card data line, open drain
  input wire logic card_data_in,
  output logic card_data_out,
  output logic card_data_oe_out,
  // card clock pin
  input wire logic card_clk_in,
  output logic card_clk_out,
  output logic card_clk_oe_out,
  // request lines
  output logic fault_irq_out,
  output logic receive_interrupt_out,
  output logic transmit_interrupt_out
);

  // ==========================================================
  // registers
  logic parity_odd_reg;
  logic card_mode_select_reg;
  scr_pkg::scr_ctrl_t ctrl_reg;
  scr_pkg::scr_flags_t flags_reg;
  logic [7:0] tx_data_reg;
  logic [7:0] rx_data_reg;
  logic [7:0] bit_rate_reg;
  logic clk_pin_dir_reg;
  logic clk_pin_value_reg;
  logic tx_pend_reg;

  // bus
  logic wr_take;
  logic rd_load;
  logic [31:0] rd_next;
  logic flags_wr;

  // pins
  logic data_meta_reg;
  logic data_sync_reg;
  logic clk_meta_reg;
  logic clk_sync_reg;

  // engine
  scr_pkg::scr_state_t state_reg;
  logic tx_mode_reg;
  logic [8:0] pulse_reg;
  logic [3:0] bit_reg;
  logic line_prev_reg;
  logic [7:0] shift_reg;
  logic rx_err_reg;
  logic tx_err_reg;
  logic base_tick;
  logic sck_level;
  logic sck_running;
  logic engine_on;
  logic sample_now;
  logic bit_end;
  logic frame_end;
  logic [9:0] tx_frame;
  logic rx_par_bad;
  logic set_parity_fault;
  logic set_rx_full;
  logic set_error_signal;
  logic set_tx_done;
  logic par_slot;
  logic err_probe;

  assign wr_take = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  assign flags_wr = wr_take && avs_address_in == scr_pkg::OFS_SERIAL_FLAGS;
  assign rd_load = avs_read_in && avs_waitrequest_out;
  assign engine_on = card_mode_select_reg && (ctrl_reg.tx_on || ctrl_reg.rx_on);
  assign sample_now = base_tick && (state_reg == scr_pkg::ST_FRAME) &&
                      (pulse_reg == scr_pkg::SAMPLE_PULSE);
  assign bit_end = pulse_reg == scr_pkg::BASE_PER_BIT;
  assign frame_end = base_tick && (state_reg == scr_pkg::ST_FRAME) && bit_end &&
                     (bit_reg == scr_pkg::BIT_LAST);
  assign tx_frame = {(^tx_data_reg) ^ parity_odd_reg, tx_data_reg, 1'b0};
  assign rx_par_bad = ((^shift_reg) ^ data_sync_reg) != parity_odd_reg;
  assign par_slot = sample_now && !tx_mode_reg && bit_reg == scr_pkg::BIT_PARITY;
  assign err_probe = base_tick && tx_mode_reg && bit_reg == scr_pkg::BIT_ERR_CLOSE &&
                     pulse_reg == scr_pkg::ERR_PROBE_PULSE;

  // ==========================================================
  // base clock and card clock
  scr_clk_gen u_clk_gen (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .enable_in(card_mode_select_reg),
    .half_div_in(bit_rate_reg),
    .clk_out_on_in(ctrl_reg.clk_out_on),
    .fix_level_in(ctrl_reg.clk_fixed_level),
    .base_tick_out(base_tick),
    .sck_level_out(sck_level),
    .running_out(sck_running)
  );

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      data_meta_reg <= 1'b1;
      data_sync_reg <= 1'b1;
      clk_meta_reg <= 1'b0;
      clk_sync_reg <= 1'b0;
    end else begin
      data_meta_reg <= card_data_in;
      data_sync_reg <= data_meta_reg;
      clk_meta_reg <= card_clk_in;
      clk_sync_reg <= clk_meta_reg;
    end
  end

  // ==========================================================
  // bus handshake: one wait cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (avs_address_in)
      scr_pkg::OFS_SERIAL_MODE: rd_next[scr_pkg::MODE_PARITY_ODD] = parity_odd_reg;
      scr_pkg::OFS_CARD_MODE: rd_next[scr_pkg::CARD_MODE_SELECT] = card_mode_select_reg;
      scr_pkg::OFS_SERIAL_CONTROL: rd_next[5:0] = ctrl_reg;
      scr_pkg::OFS_SERIAL_FLAGS: begin
        rd_next[3:0] = flags_reg;
        rd_next[scr_pkg::FLAG_BUSY] = state_reg == scr_pkg::ST_FRAME;
      end
      scr_pkg::OFS_TX_DATA: rd_next[7:0] = tx_data_reg;
      scr_pkg::OFS_RX_DATA: rd_next[7:0] = rx_data_reg;
      scr_pkg::OFS_BIT_RATE: rd_next[7:0] = bit_rate_reg;
      scr_pkg::OFS_PORT: begin
        rd_next[scr_pkg::PORT_CLK_DIR] = clk_pin_dir_reg;
        rd_next[scr_pkg::PORT_CLK_VALUE] = clk_pin_value_reg;
        rd_next[scr_pkg::PORT_CLK_PIN] = clk_sync_reg;
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (rd_load) begin
      avs_readdata_out <= rd_next;
    end
  end

  // ==========================================================
  // software-written configuration
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      parity_odd_reg <= 1'b0;
      card_mode_select_reg <= 1'b0;
      ctrl_reg <= '0;
      tx_data_reg <= 8'h00;
      bit_rate_reg <= scr_pkg::BIT_RATE_RESET;
      clk_pin_dir_reg <= 1'b0;
      clk_pin_value_reg <= 1'b0;
    end else if (wr_take) begin
      unique case (avs_address_in)
        scr_pkg::OFS_SERIAL_MODE: parity_odd_reg <= avs_writedata_in[scr_pkg::MODE_PARITY_ODD];
        scr_pkg::OFS_CARD_MODE: card_mode_select_reg <= avs_writedata_in[scr_pkg::CARD_MODE_SELECT];
        scr_pkg::OFS_SERIAL_CONTROL: ctrl_reg <= avs_writedata_in[5:0];
        scr_pkg::OFS_TX_DATA: tx_data_reg <= avs_writedata_in[7:0];
        scr_pkg::OFS_BIT_RATE: bit_rate_reg <= avs_writedata_in[7:0];
        scr_pkg::OFS_PORT: begin
          clk_pin_dir_reg <= avs_writedata_in[scr_pkg::PORT_CLK_DIR];
          clk_pin_value_reg <= avs_writedata_in[scr_pkg::PORT_CLK_VALUE];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // frame engine: direction chosen at frame start
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= scr_pkg::ST_IDLE;
      tx_mode_reg <= 1'b0;
      pulse_reg <= 9'h001;
      bit_reg <= 4'h0;
      line_prev_reg <= 1'b1;
    end else if (!engine_on) begin
      state_reg <= scr_pkg::ST_IDLE;
      line_prev_reg <= 1'b1;
    end else if (base_tick) begin
      line_prev_reg <= data_sync_reg;
      unique case (state_reg)
        scr_pkg::ST_IDLE: begin
          pulse_reg <= 9'h001;
          bit_reg <= scr_pkg::BIT_START;
          if (ctrl_reg.tx_on && tx_pend_reg) begin
            state_reg <= scr_pkg::ST_FRAME;
            tx_mode_reg <= 1'b1;
          end else if (ctrl_reg.rx_on && line_prev_reg && !data_sync_reg) begin
            state_reg <= scr_pkg::ST_FRAME;
            tx_mode_reg <= 1'b0;
          end
        end
        scr_pkg::ST_FRAME: begin
          if (!tx_mode_reg && sample_now && bit_reg == scr_pkg::BIT_START && data_sync_reg) begin
            state_reg <= scr_pkg::ST_IDLE; // start bit was a glitch
          end else if (bit_end) begin
            pulse_reg <= 9'h001;
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == scr_pkg::BIT_LAST) begin
              state_reg <= scr_pkg::ST_IDLE;
            end
          end else begin
            pulse_reg <= pulse_reg + 9'h001;
          end
        end
      endcase
    end
  end

  // receive shifting; data kept even on parity fault
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      rx_err_reg <= 1'b0;
      tx_err_reg <= 1'b0;
    end else if (state_reg == scr_pkg::ST_IDLE) begin
      rx_err_reg <= 1'b0;
      tx_err_reg <= 1'b0;
    end else if (sample_now && !tx_mode_reg) begin
      if (bit_reg > scr_pkg::BIT_START && bit_reg < scr_pkg::BIT_PARITY) begin
        shift_reg <= {data_sync_reg, shift_reg[7:1]};
      end
      if (bit_reg == scr_pkg::BIT_PARITY) begin
        rx_data_reg <= shift_reg;
        rx_err_reg <= rx_par_bad;
      end
    end else if (err_probe) begin
      tx_err_reg <= !data_sync_reg;
    end
  end

  assign set_parity_fault = par_slot && rx_par_bad;
  assign set_rx_full = par_slot && !rx_par_bad;
  assign set_error_signal = err_probe && !data_sync_reg;
  assign set_tx_done = frame_end && tx_mode_reg && !tx_err_reg;

  // ==========================================================
  // flags: hardware set wins over clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_reg <= '0;
      flags_reg.tx_done_flag <= scr_pkg::TX_DONE_RESET;
      tx_pend_reg <= 1'b0;
    end else begin
      if (set_parity_fault) begin
        flags_reg.parity_fault_flag <= 1'b1;
      end else if (flags_wr && !avs_writedata_in[scr_pkg::FLAG_PARITY_FAULT]) begin
        flags_reg.parity_fault_flag <= 1'b0;
      end
      if (set_rx_full) begin
        flags_reg.receive_full_flag <= 1'b1;
      end else if (flags_wr && !avs_writedata_in[scr_pkg::FLAG_RX_FULL]) begin
        flags_reg.receive_full_flag <= 1'b0;
      end
      if (set_error_signal) begin
        flags_reg.error_signal_flag <= 1'b1;
      end else if (flags_wr && !avs_writedata_in[scr_pkg::FLAG_ERROR_SIGNAL]) begin
        flags_reg.error_signal_flag <= 1'b0;
      end
      if (set_tx_done) begin
        flags_reg.tx_done_flag <= 1'b1;
        tx_pend_reg <= 1'b0; // kept on error so the frame repeats
      end else if (wr_take && avs_address_in == scr_pkg::OFS_TX_DATA) begin
        flags_reg.tx_done_flag <= 1'b0;
        tx_pend_reg <= 1'b1;
      end else if (flags_wr && !avs_writedata_in[scr_pkg::FLAG_TX_DONE]) begin
        flags_reg.tx_done_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // request lines
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_irq_out <= 1'b0;
      receive_interrupt_out <= 1'b0;
      transmit_interrupt_out <= 1'b0;
    end else begin
      fault_irq_out <= ctrl_reg.rx_irq_mask &&
                       (flags_reg.parity_fault_flag || flags_reg.error_signal_flag);
      receive_interrupt_out <= ctrl_reg.rx_irq_mask && flags_reg.receive_full_flag;
      transmit_interrupt_out <= ctrl_reg.tx_irq_mask && flags_reg.tx_done_flag;
    end
  end

  // ==========================================================
  // pin drivers; open drain, so a one is a release
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      card_data_out <= 1'b0;
      card_data_oe_out <= 1'b0;
    end else if (!engine_on || state_reg != scr_pkg::ST_FRAME) begin
      card_data_oe_out <= 1'b0;
    end else if (tx_mode_reg) begin
      card_data_oe_out <= bit_reg <= scr_pkg::BIT_PARITY && !tx_frame[bit_reg];
    end else begin
      card_data_oe_out <= rx_err_reg &&
        ((bit_reg == scr_pkg::BIT_ERR_OPEN && pulse_reg >= scr_pkg::SAMPLE_PULSE) ||
         (bit_reg == scr_pkg::BIT_ERR_CLOSE && pulse_reg < scr_pkg::SAMPLE_PULSE));
    end
  end

  // outside card mode a plain port
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      card_clk_out <= 1'b0;
      card_clk_oe_out <= 1'b0;
    end else if (card_mode_select_reg) begin
      card_clk_out <= sck_level;
      card_clk_oe_out <= ctrl_reg.clk_out_on || sck_running || ctrl_reg.clk_fixed_level;
    end else begin
      card_clk_out <= clk_pin_value_reg;
      card_clk_oe_out <= clk_pin_dir_reg;
    end
  end

endmodule // scr_top
`default_nettype wire

// [tb/scr_card_model.sv]
// card model: frames on the data line, timed by the clock pin
`timescale 1ns/1ps
`default_nettype none
module scr_card_model (
  // pins
  input wire logic clk_pin_in,
  input wire logic line_in,
  output logic pull_low_out,
  // bench control
  input wire logic nak_in,
  input wire logic send_in,
  input wire logic [7:0] send_byte_in,
  input wire logic bad_par_in,
  // results
  output logic [7:0] got_byte_out,
  output logic got_ok_out,
  output logic nak_seen_out,
  output logic [7:0] frames_out
);
  logic [9:0] sh;
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_pin_in);
  endtask
  initial begin
    pull_low_out = 1'b0;
    got_byte_out = 8'h00;
    got_ok_out = 1'b0;
    nak_seen_out = 1'b0;
    frames_out = 8'h00;
    forever begin
      @(posedge send_in or negedge line_in);
      if (send_in) begin
        sh = {^send_byte_in ^ bad_par_in, send_byte_in, 1'b0};
        for (int i = 0; i < 10; i++) begin
          pull_low_out = !sh[i];
          ticks(372);
        end
        pull_low_out = 1'b0;
        ticks(372);
        nak_seen_out = !line_in;
        ticks(372);
      end else begin
        for (int i = 0; i < 10; i++) begin
          ticks(i == 0 ? 186 : 372);
          sh[i] = line_in;
        end
        got_byte_out = sh[8:1];
        got_ok_out = !(^sh[9:1]);
        ticks(372);
        pull_low_out = nak_in;
        ticks(372);
        pull_low_out = 1'b0;
        // short of frame end, to catch a prompt repeat
        ticks(180);
      end
      frames_out = frames_out + 8'h01;
    end
  end
endmodule // scr_card_model
`default_nettype wire

// [tb/scr_chk.sv]
// checker: port-level properties of the card serial block
`timescale 1ns/1ps
`default_nettype none
module scr_chk (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // register bus
  input wire logic [4:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_read_in,
  input wire logic avs_waitrequest_out,
  // pins and requests
  input wire logic card_data_oe_out,
  input wire logic card_clk_out,
  input wire logic card_clk_oe_out,
  input wire logic fault_irq_out,
  input wire logic receive_interrupt_out,
  input wire logic transmit_interrupt_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic wr_ok;
  logic cm_q;
  logic [7:0] ctl_q;
  logic [7:0] div_q;
  logic [2:0] on_cnt;
  logic [9:0] off_cnt;
  logic [8:0] h_cnt;
  logic [1:0] tg;
  logic last_clk;
  // ==========================================================
  // shadows of accepted writes
  assign wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cm_q <= 1'b0;
      ctl_q <= 8'h00;
      div_q <= scr_pkg::BIT_RATE_RESET;
    end else if (wr_ok) begin
      if (avs_address_in == scr_pkg::OFS_CARD_MODE) cm_q <= avs_writedata_in[0];
      if (avs_address_in == scr_pkg::OFS_SERIAL_CONTROL) ctl_q <= avs_writedata_in[7:0];
      if (avs_address_in == scr_pkg::OFS_BIT_RATE) div_q <= avs_writedata_in[7:0];
    end
  end
  // ==========================================================
  // clock run, stop and half-period counters
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      on_cnt <= 3'h0;
      off_cnt <= 10'h000;
    end else begin
      if (!(cm_q && ctl_q[scr_pkg::CTRL_CLK_OUT_ON])) on_cnt <= 3'h0;
      else if (on_cnt != 3'h7) on_cnt <= on_cnt + 3'h1;
      if (!cm_q || ctl_q[scr_pkg::CTRL_CLK_OUT_ON] || wr_ok) off_cnt <= 10'h000;
      else if (off_cnt != 10'h258) off_cnt <= off_cnt + 10'h001;
    end
  end
  // holds and rate changes restart the count
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      last_clk <= 1'b0;
      h_cnt <= 9'h000;
      tg <= 2'h0;
    end else begin
      last_clk <= card_clk_out;
      h_cnt <= (card_clk_out != last_clk) ? 9'h000 : h_cnt + 9'h001;
      if (!cm_q || h_cnt > 9'h12C || (wr_ok && avs_address_in == scr_pkg::OFS_BIT_RATE))
        tg <= 2'h0;
      else if (card_clk_out != last_clk && tg != 2'h3)
        tg <= tg + 2'h1;
    end
  end
  // ==========================================================
  // assertions
  a_pins_after_reset: assert property ($fell(rst_in) |-> !card_clk_oe_out && !card_data_oe_out)
    else $error("pins driven right after reset");
  a_bus_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus wait not exactly one cycle");
  a_rx_mask_gate: assert property (!ctl_q[5] && !$past(ctl_q[5]) |-> !fault_irq_out && !receive_interrupt_out)
    else $error("receive side request while masked");
  a_tx_mask_gate: assert property (!ctl_q[4] && !$past(ctl_q[4]) |-> !transmit_interrupt_out)
    else $error("transmit request while masked");
  a_tx_done_clear: assert property (wr_ok && avs_address_in == scr_pkg::OFS_TX_DATA |-> ##3 !transmit_interrupt_out [*8])
    else $error("transmit request not withdrawn on new data");
  a_clk_drive_on: assert property (on_cnt == 3'h7 |-> card_clk_oe_out)
    else $error("card clock pin not driven");
  a_clk_stop_level: assert property (off_cnt == 10'h258 |-> !card_clk_oe_out || card_clk_out == ctl_q[3])
    else $error("stopped clock not at fixed level");
  a_clk_half_period: assert property (card_clk_out != last_clk && tg[1] && cm_q |-> h_cnt == {1'b0, div_q})
    else $error("card clock half period wrong");
  c_clk_run: cover property (on_cnt == 3'h7);
  c_fault: cover property ($rose(fault_irq_out));
  c_rx_full: cover property ($rose(receive_interrupt_out));
endmodule // scr_chk
bind scr_top scr_chk i_scr_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_read_in(avs_read_in),
  .avs_waitrequest_out(avs_waitrequest_out), .card_data_oe_out(card_data_oe_out),
  .card_clk_out(card_clk_out), .card_clk_oe_out(card_clk_oe_out),
  .fault_irq_out(fault_irq_out), .receive_interrupt_out(receive_interrupt_out),
  .transmit_interrupt_out(transmit_interrupt_out)
);
`default_nettype wire

// [tb/test_scr_top.sv]
// testbench: card serial block against a card model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module test_scr_top;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wreq, d_oe, c_out, c_oe, f_irq, r_irq, t_irq, pull, got_ok, nak_seen;
  logic nak = 1'b0;
  logic snd = 1'b0;
  logic bad = 1'b0;
  logic [7:0] sb = 8'h00;
  logic [7:0] nf = 8'h00;
  logic [7:0] got, frames;
  int n_tests = 0;
  int num_errors = 0;
  // both lines pulled up
  wire logic c_pin = c_oe ? c_out : 1'b1;
  wire logic line = !(d_oe || pull);
  scr_top i_scr_top (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in({24'h000000, wd}),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .card_data_in(line), .card_data_out(), .card_data_oe_out(d_oe), .card_clk_in(c_pin),
    .card_clk_out(c_out), .card_clk_oe_out(c_oe), .fault_irq_out(f_irq),
    .receive_interrupt_out(r_irq), .transmit_interrupt_out(t_irq));
  scr_card_model i_scr_card_model (.clk_pin_in(c_pin), .line_in(line), .pull_low_out(pull),
    .nak_in(nak), .send_in(snd), .send_byte_in(sb), .bad_par_in(bad), .got_byte_out(got),
    .got_ok_out(got_ok), .nak_seen_out(nak_seen), .frames_out(frames));
  initial forever #10 mclk_in = ~mclk_in;
  // ==========================================================
  // shared tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge mclk_in); while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic frame_wait;
    nf++;
    repeat (12000) begin
      @(posedge mclk_in);
      if (frames === nf) break;
    end
    repeat (400) @(posedge mclk_in);
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    sb <= b;
    bad <= e;
    snd <= 1'b1;
    @(posedge mclk_in);
    snd <= 1'b0;
    frame_wait;
  endtask
  task automatic toggles(input logic [7:0] e);
    logic [7:0] n;
    logic l;
    repeat (40) @(posedge mclk_in);
    n = 8'h00;
    l = c_out;
    repeat (64) begin
      @(posedge mclk_in);
      if (c_out !== l) n++;
      l = c_out;
    end
    `CHK("clk_edges", e, n)
  endtask
  // ==========================================================
  // scenarios
  task automatic t_clock;
    `CHK("clk_oe", 1'b0, c_oe)
    bus(1'b1, scr_pkg::OFS_SERIAL_CONTROL, 8'h08);
    repeat (4) @(posedge mclk_in);
    `CHK("clk_fixed", 1'b1, c_pin)
    bus(1'b1, scr_pkg::OFS_SERIAL_MODE, 8'h00);
    bus(1'b1, scr_pkg::OFS_CARD_MODE, 8'h01);
    bus(1'b1, scr_pkg::OFS_SERIAL_CONTROL, 8'h0C);
    toggles(8'h10);
    bus(1'b1, scr_pkg::OFS_PORT, 8'h03);
    bus(1'b1, scr_pkg::OFS_SERIAL_CONTROL, 8'h08);
    repeat (700) @(posedge mclk_in);
    toggles(8'h00);
    `CHK("clk_held", 2'b11, {c_oe, c_out})
    bus(1'b1, scr_pkg::OFS_SERIAL_MODE, 8'h00);
    bus(1'b1, scr_pkg::OFS_CARD_MODE, 8'h00);
    repeat (4) @(posedge mclk_in);
    `CHK("clk_standby", 2'b11, {c_oe, c_out})
    bus(1'b1, scr_pkg::OFS_CARD_MODE, 8'h01);
    bus(1'b1, scr_pkg::OFS_SERIAL_CONTROL, 8'h0C);
    toggles(8'h10);
    bus(1'b1, scr_pkg::OFS_BIT_RATE, 8'h00);
  endtask
  task automatic t_tx;
    bus(1'b1, scr_pkg::OFS_SERIAL_CONTROL, 8'h3D);
    bus(1'b1, scr_pkg::OFS_TX_DATA, 8'hA5);
    frame_wait;
    `CHK("tx_byte", 8'hA5, got)
    `CHK("tx_par", 1'b1, got_ok)
    `CHK("tx_irq", 1'b1, t_irq)
    bus(1'b0, scr_pkg::OFS_SERIAL_FLAGS, 8'h00);
    `CHK("err_flag", 1'b0, q[scr_pkg::FLAG_ERROR_SIGNAL])
    nak <= 1'b1;
    bus(1'b1, scr_pkg::OFS_TX_DATA, 8'h3C);
    frame_wait;
    `CHK("nak_tx_irq", 1'b0, t_irq)
    `CHK("nak_fault", 1'b1, f_irq)
    nak <= 1'b0;
    bus(1'b1, scr_pkg::OFS_SERIAL_FLAGS, 8'h00);
    frame_wait;
    `CHK("retx_byte", 8'h3C, got)
    `CHK("retx_irq", 1'b1, t_irq)
    `CHK("retx_fault", 1'b0, f_irq)
  endtask
  task automatic t_rx;
    bus(1'b1, scr_pkg::OFS_SERIAL_CONTROL, 8'h2E);
    send(8'h5A, 1'b1);
    `CHK("err_drive", 1'b1, nak_seen)
    `CHK("par_fault", 1'b1, f_irq)
    `CHK("no_rx_full", 1'b0, r_irq)
    bus(1'b1, scr_pkg::OFS_SERIAL_FLAGS, 8'h00);
    send(8'h5A, 1'b0);
    `CHK("no_err_drive", 1'b0, nak_seen)
    `CHK("rx_full", 1'b1, r_irq)
    `CHK("rx_fault", 1'b0, f_irq)
    bus(1'b0, scr_pkg::OFS_RX_DATA, 8'h00);
    `CHK("rx_byte", 8'h5A, q[7:0])
  endtask
  initial begin
    repeat (80000) @(posedge mclk_in);
    num_errors++;
    $display("[FAIL] run_time exp finished got hung");
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_clock;
    t_tx;
    t_rx;
    give_verdict;
  end
endmodule // test_scr_top
`default_nettype wire
